// >>> logic/dpra_host.sv
// Host controller driving one port of a dual-port static RAM
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Reading with busy low: wait write-to-read delay before trusting data.
// - Master busy is open-drain output; slave busy is an input.
// - Host keeps strobe or select high while address changes.
// - Host holds write pulse for the write pulse width, rounded up to whole clocks.
// - Host never drives data while port still drives outputs.
// - Write protocol applies per byte lane strobe.
module dpra_host
	import dpra_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        resetn,
	// AXI4-Lite slave
	input  wire logic [3:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [3:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// RAM port pins
	output logic [dpra_pkg::ADDR_W-1:0]      word_address,
	output logic                             select_n,
	output logic                             out_enable_n,
	output logic                             lower_lane_write_n,
	output logic                             upper_lane_write_n,
	input  wire logic [dpra_pkg::LANE_W-1:0] lower_data_lane_i,
	output logic [dpra_pkg::LANE_W-1:0]      lower_data_lane_o,
	output logic                             lower_data_lane_oe,
	input  wire logic [dpra_pkg::LANE_W-1:0] upper_data_lane_i,
	output logic [dpra_pkg::LANE_W-1:0]      upper_data_lane_o,
	output logic                             upper_data_lane_oe,
	input  wire logic                        busy_n
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [DATA_W:0] pins_s;
	dpra_sync #(.W(DATA_W + 1)) u_sync (
		.mclk   (mclk),
		.resetn (resetn),
		.d      ({busy_n, upper_data_lane_i, lower_data_lane_i}),
		.q      (pins_s)
	);
	logic busy_s;
	assign busy_s = pins_s[DATA_W];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] rdata_q;
	logic              wr_q;
	logic [1:0]        lanes_q;
	logic              start_q;
	logic              done_q;
	logic              blocked_q;
	dpra_state_e       state_q;
	logic [CNT_W-1:0]  cnt_q;

	// ----------------------------------------
	// AXI4-Lite write
	// ----------------------------------------
	logic aw_hold_q;
	logic w_hold_q;
	logic [3:0] awaddr_q;
	logic [15:0] wd_q;
	logic wr_fire;
	assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			awaddr_q      <= 4'h0;
			wd_q          <= 16'h0000;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q     <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q     <= 1'b1;
				wd_q         <= s_axi_wdata[15:0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == OFF_STAT || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software-written registers; start pulse only while idle
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			addr_q  <= '0;
			wdata_q <= '0;
			wr_q    <= 1'b0;
			lanes_q <= 2'h3;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= 1'b0;
			if (wr_fire)
			begin
				unique case (awaddr_q)
					OFF_CTRL:
					begin
						wr_q    <= wd_q[CTRL_WR];
						lanes_q <= wd_q[CTRL_LANE_HI:CTRL_LANE_LO];
						start_q <= wd_q[CTRL_GO] && state_q == ST_IDLE;
					end
					OFF_ADDR:  addr_q <= wd_q[ADDR_W-1:0];
					OFF_WDATA: wdata_q <= wd_q;
					default:   ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// AXI4-Lite read
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			unique case (s_axi_araddr)
				OFF_CTRL:  s_axi_rdata <= {28'h0, lanes_q, wr_q, 1'b0};
				OFF_ADDR:  s_axi_rdata <= {21'h0, addr_q};
				OFF_WDATA: s_axi_rdata <= {16'h0, wdata_q};
				OFF_STAT:  s_axi_rdata <= {rdata_q, 13'h0, blocked_q, done_q,
					state_q == ST_IDLE};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Port sequencer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q            <= ST_IDLE;
			cnt_q              <= CNT_ZERO;
			word_address       <= '0;
			select_n           <= 1'b1;
			out_enable_n       <= 1'b1;
			lower_lane_write_n <= 1'b1;
			upper_lane_write_n <= 1'b1;
			lower_data_lane_o  <= '0;
			upper_data_lane_o  <= '0;
			lower_data_lane_oe <= 1'b0;
			upper_data_lane_oe <= 1'b0;
			rdata_q            <= '0;
			done_q             <= 1'b0;
			blocked_q          <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					if (start_q)
					begin
						done_q       <= 1'b0;
						blocked_q    <= 1'b0;
						// Address set while select is high
						word_address <= addr_q;
						state_q      <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					select_n <= 1'b0;
					cnt_q    <= CNT_ZERO;
					if (wr_q)
					begin
						// Output enable held high so port never drives
						out_enable_n       <= 1'b1;
						lower_data_lane_o  <= wdata_q[LANE_W-1:0];
						upper_data_lane_o  <= wdata_q[DATA_W-1:LANE_W];
						lower_data_lane_oe <= lanes_q[0];
						upper_data_lane_oe <= lanes_q[1];
						// Strobes fall with select, so the port's outputs stay floating
						lower_lane_write_n <= !lanes_q[0];
						upper_lane_write_n <= !lanes_q[1];
						state_q            <= ST_STROBE;
					end
					else
					begin
						out_enable_n <= 1'b0;
						state_q      <= ST_READ;
					end
				end
				ST_STROBE:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (!busy_s)
						blocked_q <= 1'b1;
					if (cnt_q == CNT_W'(WP_CYC - 1))
					begin
						// Write ends on strobe rise, select still low
						lower_lane_write_n <= 1'b1;
						upper_lane_write_n <= 1'b1;
						cnt_q              <= CNT_ZERO;
						state_q            <= ST_RECOVER;
					end
				end
				ST_RECOVER:
				begin
					select_n           <= 1'b1;
					lower_data_lane_oe <= 1'b0;
					upper_data_lane_oe <= 1'b0;
					done_q             <= 1'b1;
					state_q            <= ST_IDLE;
				end
				ST_READ:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (!busy_s)
						blocked_q <= 1'b1;
					if (cnt_q == CNT_W'(ACC_CYC + 1))
					begin
						cnt_q <= CNT_ZERO;
						// Contended read waits the write-to-read delay
						state_q <= ST_WAIT;
						if (busy_s && !blocked_q)
							cnt_q <= CNT_W'(WDD_CYC);
					end
				end
				ST_WAIT:
				begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q >= CNT_W'(WDD_CYC))
					begin
						rdata_q      <= pins_s[DATA_W-1:0];
						out_enable_n <= 1'b1;
						select_n     <= 1'b1;
						done_q       <= 1'b1;
						state_q      <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_addr_stable;
		@(posedge mclk) disable iff (!resetn)
		!$stable(word_address) |-> $past(select_n) && select_n;
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved while selected");

	property p_pulse_width;
		@(posedge mclk) disable iff (!resetn)
		$fell(lower_lane_write_n & upper_lane_write_n) |->
			!(lower_lane_write_n & upper_lane_write_n) [*5];
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("write pulse too short");

	property p_no_clash;
		@(posedge mclk) disable iff (!resetn)
		(lower_data_lane_oe || upper_data_lane_oe) |-> out_enable_n;
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("host drives while port may drive");

	property p_select_first;
		@(posedge mclk) disable iff (!resetn)
		$fell(lower_lane_write_n & upper_lane_write_n) |-> $fell(select_n);
	endproperty
	a_select_first: assert property (p_select_first) else $error("strobe after select");

	property p_strobe_in_select;
		@(posedge mclk) disable iff (!resetn)
		!(lower_lane_write_n && upper_lane_write_n) |-> !select_n ##1 !select_n;
	endproperty
	a_strobe_in_select: assert property (p_strobe_in_select) else $error("strobe outside select");

	property p_lane_match;
		@(posedge mclk) disable iff (!resetn)
		!lower_lane_write_n |-> lower_data_lane_oe;
	endproperty
	a_lane_match: assert property (p_lane_match) else $error("lower strobe without data");

	property p_read_oe;
		@(posedge mclk) disable iff (!resetn)
		$fell(out_enable_n) |-> lower_lane_write_n && upper_lane_write_n && !select_n;
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("read enable during write");

	property p_done_after;
		@(posedge mclk) disable iff (!resetn)
		start_q |-> ##[1:40] done_q;
	endproperty
	a_done_after: assert property (p_done_after) else $error("access never finished");
endmodule : dpra_host

// >>> logic/dpra_pkg.sv
// Package: constants for the dual-port RAM host controller
package dpra_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// Register byte offsets
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_ADDR = 4'h4;
	localparam logic [3:0] OFF_WDATA = 4'h8;
	localparam logic [3:0] OFF_STAT = 4'hc;
	// Control fields
	localparam int CTRL_GO = 0;
	localparam int CTRL_WR = 1;
	localparam int CTRL_LANE_LO = 2;
	localparam int CTRL_LANE_HI = 3;
	// Status fields
	localparam int STAT_BUSY_IDLE = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_BLOCKED = 2;
	localparam int STAT_RDATA = 16;
	// Timing
	localparam int CLK_NS = 20;
	localparam int WRITE_PULSE_WIDTH_NS = 90;
	localparam int WRITE_PULSE_TO_READ_DELAY_NS = 100;
	localparam int ACCESS_NS = 90;
	localparam int WP_CYC = (WRITE_PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int WDD_CYC = (WRITE_PULSE_TO_READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_READ, ST_WAIT
	} dpra_state_e;
endpackage : dpra_pkg

// >>> logic/dpra_sync.sv
// Two-flop synchroniser
`timescale 1ns/10ps
module dpra_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_q <= '0;
			q      <= '0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : dpra_sync

// >>> tb/dpra_host_bench.sv
// Testbench for the dual-port RAM host controller
`timescale 1ns/10ps
module dpra_host_bench;
	import dpra_pkg::*;
	logic              mclk = 1'b0;
	logic              resetn = 1'b0;
	logic [3:0]        s_axi_awaddr = 4'h0;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready = 1'b1;
	logic [3:0]        s_axi_araddr = 4'h0;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready = 1'b1;
	logic [ADDR_W-1:0] word_address;
	logic              select_n, out_enable_n, lower_lane_write_n, upper_lane_write_n;
	logic [LANE_W-1:0] lower_data_lane_i, lower_data_lane_o;
	logic [LANE_W-1:0] upper_data_lane_i, upper_data_lane_o;
	logic              lower_data_lane_oe, upper_data_lane_oe, busy_n;
	logic              far_select_n = 1'b1;
	logic [ADDR_W-1:0] far_address = '0;
	logic              far_busy_n;
	logic [31:0]       st;
	logic [1:0]        r;
	int                mismatches = 0;
	int                compares = 0;

	always #10 mclk = ~mclk;

	dpra_host uut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .word_address,
		.select_n, .out_enable_n, .lower_lane_write_n, .upper_lane_write_n,
		.lower_data_lane_i, .lower_data_lane_o, .lower_data_lane_oe,
		.upper_data_lane_i, .upper_data_lane_o, .upper_data_lane_oe, .busy_n);
	dpra_ram_model ram (.word_address, .select_n, .out_enable_n, .lower_lane_write_n,
		.upper_lane_write_n, .lower_data_lane_o, .lower_data_lane_oe,
		.upper_data_lane_o, .upper_data_lane_oe, .far_select_n, .far_address,
		.lower_data_lane_i, .upper_data_lane_i, .busy_n, .far_busy_n);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic end_sim;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rs = s_axi_rresp;
	endtask : axi_rd

	// One RAM access, then poll status until done
	task automatic op(input logic [10:0] a, input logic [15:0] d, input logic [3:0] c);
		int n;
		axi_wr(OFF_ADDR, {21'h0, a}, r);
		axi_wr(OFF_WDATA, {16'h0, d}, r);
		axi_wr(OFF_CTRL, {28'h0, c}, r);
		check(r, 2'b00);
		repeat (3) @(posedge mclk);
		n = 0;
		do
		begin
			axi_rd(OFF_STAT, st, r);
			n++;
		end
		while (st[STAT_DONE] !== 1'b1 && n < 100);
		check(st[STAT_DONE], 1'b1);
	endtask : op

	// Far port takes the host's address lag cycles after the host selects
	task automatic far_join(input int lag, input logic [1:0] exp);
		@(negedge select_n);
		repeat (lag) @(posedge mclk);
		far_address  <= word_address;
		far_select_n <= 1'b0;
		repeat (2) @(posedge mclk);
		check({busy_n, far_busy_n}, exp);
		check(out_enable_n, 1'b1);
	endtask : far_join

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		check({select_n, lower_data_lane_oe, upper_data_lane_oe}, 3'b100);
		axi_rd(OFF_STAT, st, r);
		check(st[STAT_BUSY_IDLE], 1'b1);
		op(11'h7ff, 16'h1234, 4'hf);
		check(ram.mem[11'h7ff], 16'h1234);
		check(st[STAT_BLOCKED], 1'b0);
		op(11'h7ff, 16'habcd, 4'h7);
		check(ram.mem[11'h7ff], 16'h12cd);
		op(11'h7ff, 16'h5678, 4'hb);
		check(ram.mem[11'h7ff], 16'h56cd);
		op(11'h000, 16'h9999, 4'hf);
		op(11'h7ff, 16'h0000, 4'hd);
		check(st[31:16], 16'h56cd);
		check(ram.mem[11'h000], 16'h9999);
		// Far port already selected on the address: host loses
		far_select_n <= 1'b0;
		fork
			op(11'h000, 16'h1111, 4'hf);
			far_join(0, 2'b01);
		join
		check(ram.mem[11'h000], 16'h9999);
		check(st[STAT_BLOCKED], 1'b1);
		far_select_n <= 1'b1;
		// Far port a cycle after the host: host wins
		fork
			op(11'h000, 16'h2222, 4'hf);
			far_join(1, 2'b10);
		join
		check(ram.mem[11'h000], 16'h2222);
		check(st[STAT_BLOCKED], 1'b0);
		far_select_n <= 1'b1;
		far_address  <= 11'h001;
		// Far port in the same instant as the host: one winner only
		fork
			op(11'h000, 16'h3333, 4'hf);
			far_join(0, 2'b01);
		join
		check(ram.mem[11'h000], 16'h2222);
		check(st[STAT_BLOCKED], 1'b1);
		far_select_n <= 1'b1;
		axi_rd(OFF_ADDR, st, r);
		check(st, 32'h0000_0000);
		axi_rd(OFF_WDATA, st, r);
		check(st, 32'h0000_3333);
		axi_rd(OFF_CTRL, st, r);
		check(st, 32'h0000_000e);
		axi_wr(OFF_STAT, 32'h0, r);
		check(r, 2'b10);
		axi_rd(4'h2, st, r);
		check(r, 2'b10);
		check(st, 32'h0);
		end_sim();
	end

	initial
	begin
		#(20000 * CLK_NS);
		mismatches++;
		end_sim();
	end
endmodule : dpra_host_bench

// >>> tb/dpra_ram_model.sv
// Behavioural model of one port of the shared static RAM
`timescale 1ns/10ps
module dpra_ram_model
	import dpra_pkg::*;
(
	input  wire logic [dpra_pkg::ADDR_W-1:0] word_address,
	input  wire logic                        select_n,
	input  wire logic                        out_enable_n,
	input  wire logic                        lower_lane_write_n,
	input  wire logic                        upper_lane_write_n,
	input  wire logic [dpra_pkg::LANE_W-1:0] lower_data_lane_o,
	input  wire logic                        lower_data_lane_oe,
	input  wire logic [dpra_pkg::LANE_W-1:0] upper_data_lane_o,
	input  wire logic                        upper_data_lane_oe,
	input  wire logic                        far_select_n,
	input  wire logic [dpra_pkg::ADDR_W-1:0] far_address,
	output logic [dpra_pkg::LANE_W-1:0]      lower_data_lane_i,
	output logic [dpra_pkg::LANE_W-1:0]      upper_data_lane_i,
	output logic                             busy_n,
	output logic                             far_busy_n
);
	logic [DATA_W-1:0] mem [0:2047];
	logic              lo_drv;
	logic              hi_drv;
	logic [LANE_W-1:0] lo_last = 8'h00;
	logic [LANE_W-1:0] hi_last = 8'h00;
	logic              near_s = 1'b1;
	logic              far_s = 1'b1;
	logic [ADDR_W-1:0] near_a = '0;
	logic [ADDR_W-1:0] far_a = '0;
	logic              match;
	logic              near_wins;
	logic              lo_on;
	logic              hi_on;
	logic              lo_was = 1'b0;
	logic              hi_was = 1'b0;
	logic              lo_ok = 1'b0;
	logic              hi_ok = 1'b0;
	logic [LANE_W-1:0] lo_keep = 8'h00;
	logic [LANE_W-1:0] hi_keep = 8'h00;
	realtime           near_t = 0.0;
	realtime           far_t = 0.0;
	// Read drive per lane; deselected or written lanes float
	assign lo_drv = !select_n && !out_enable_n && lower_lane_write_n;
	assign hi_drv = !select_n && !out_enable_n && upper_lane_write_n;
	// Released lanes show the inverse of their last level
	assign lower_data_lane_i = lower_data_lane_oe ? lower_data_lane_o :
		lo_drv ? mem[word_address][7:0] : ~lo_last;
	assign upper_data_lane_i = upper_data_lane_oe ? upper_data_lane_o :
		hi_drv ? mem[word_address][15:8] : ~hi_last;
	always @(lower_data_lane_i)
		if (lower_data_lane_oe || lo_drv) lo_last = lower_data_lane_i;
	always @(upper_data_lane_i)
		if (upper_data_lane_oe || hi_drv) hi_last = upper_data_lane_i;
	// Arbitration and write in one process, so a losing port never writes
	always @(select_n, word_address, far_select_n, far_address, lower_lane_write_n,
		upper_lane_write_n, lower_data_lane_i, upper_data_lane_i)
	begin
		if (select_n !== near_s || word_address !== near_a)
			near_t = $realtime;
		if (far_select_n !== far_s || far_address !== far_a)
			far_t = $realtime;
		near_s = select_n;
		near_a = word_address;
		far_s  = far_select_n;
		far_a  = far_address;
		match  = !select_n && !far_select_n && word_address == far_address;
		// Later arrival loses; within 5 ns the far port is the winner
		near_wins  = near_t + 5.0 <= far_t;
		busy_n     = !(match && !near_wins);
		far_busy_n = !(match && near_wins);
		lo_on = !select_n && !lower_lane_write_n;
		hi_on = !select_n && !upper_lane_write_n;
		if (lo_on)
		begin
			lo_keep = lower_data_lane_i;
			lo_ok   = busy_n;
		end
		if (hi_on)
		begin
			hi_keep = upper_data_lane_i;
			hi_ok   = busy_n;
		end
		// Write lands as the lane's overlap ends, unless busy held it off
		if (lo_was && !lo_on && lo_ok)
			mem[word_address][7:0] = lo_keep;
		if (hi_was && !hi_on && hi_ok)
			mem[word_address][15:8] = hi_keep;
		lo_was = lo_on;
		hi_was = hi_on;
	end
endmodule : dpra_ram_model
